//--- hdl/nct_core.sv
// Nibble core: transfers, table reads, branches, call/return, status test, AND.
`default_nettype none
`include "nct_params.svh"
module nct_core (
  input  wire logic                     MCLK_I,
  input  wire logic                     RST_N_I,
  output logic      [`NCT_W_PC-1:0]     PC_O,
  input  wire logic [`NCT_W_INSTR-1:0]  INSTR_I,
  output logic      [`NCT_W_PC-1:0]     TBL_ADDR_O,
  input  wire logic [`NCT_W_TBL-1:0]    TBL_DATA_I,
  input  wire logic [`NCT_W_ROMPTR-1:0] ROM_PTR_I,
  input  wire logic [3:0]               STATUS_I,
  output nct_pkg::nct_core_s            CORE_O
);
  import nct_pkg::*;

  function automatic logic grp_is(input logic [`NCT_W_INSTR-1:0] w, input logic [11:0] g);
    return w[15:4] == g;
  endfunction

  function automatic logic op_is(input logic [`NCT_W_INSTR-1:0] w,
                                 input logic [`NCT_W_INSTR-1:0] c);
    return w == c;
  endfunction

  nct_state_e              state;
  nct_state_e              next_state;
  logic [`NCT_W_INSTR-1:0] op;
  logic [`NCT_W_INSTR-1:0] next_op;
  logic                    call_q;
  logic                    next_call;
  logic [`NCT_W_PC-1:0]    pc;
  logic [`NCT_W_PC-1:0]    next_pc;
  logic [`NCT_W_PC-1:0]    address_stack_reg;
  logic [`NCT_W_PC-1:0]    next_asr;
  logic [`NCT_W_SP-1:0]    sp;
  logic [`NCT_W_SP-1:0]    next_sp;
  logic [3:0]              acc;
  logic [3:0]              next_acc;
  logic                    cy;
  logic                    next_cy;
  logic                    flag;
  logic                    next_flag;
  logic [3:0]              bank0 [`NCT_NREG];
  logic [3:0]              bank1 [`NCT_NREG];
  logic                    wr_b0;
  logic                    wr_b1;
  logic [3:0]              wr_d0;
  logic [3:0]              wr_d1;

  wire [3:0] idx    = INSTR_I[3:0];
  wire [7:0] opnd8  = INSTR_I[7:0];
  wire [3:0] opnd4  = INSTR_I[3:0];
  wire [3:0] tbl_hi = TBL_DATA_I[7:4];
  wire [3:0] tbl_lo = TBL_DATA_I[3:0];
  wire [3:0] reg_b0 = bank0[idx];
  wire [3:0] reg_b1 = bank1[idx];
  // Pair zero joins bank 1 over bank 0
  wire [7:0] pair0 = {bank1[`NCT_IDX_ZERO], bank0[`NCT_IDX_ZERO]};
  assign TBL_ADDR_O = {ROM_PTR_I, pair0};

  // First-word decode
  wire f_mov_b0  = grp_is(INSTR_I, `NCT_G_MOVE_ACC_B0);
  wire f_mov_b1  = grp_is(INSTR_I, `NCT_G_MOVE_ACC_B1);
  wire f_st_b0   = grp_is(INSTR_I, `NCT_G_MOVE_B0_ACC);
  wire f_st_b1   = grp_is(INSTR_I, `NCT_G_MOVE_B1_ACC);
  wire f_pimm    = grp_is(INSTR_I, `NCT_G_PAIR_IMM);
  wire f_ptbl    = grp_is(INSTR_I, `NCT_G_PAIR_TBL);
  wire f_and_b0  = grp_is(INSTR_I, `NCT_G_AND_B0);
  wire f_and_b1  = grp_is(INSTR_I, `NCT_G_AND_B1);
  wire f_sts_reg = grp_is(INSTR_I, `NCT_G_STATUS_REG);
  wire f_tbl_hi  = op_is(INSTR_I, `NCT_OP_MOVE_TBL_HI);
  wire f_tbl_lo  = op_is(INSTR_I, `NCT_OP_MOVE_TBL_LO);
  wire f_atbl_hi = op_is(INSTR_I, `NCT_OP_AND_TBL_HI);
  wire f_atbl_lo = op_is(INSTR_I, `NCT_OP_AND_TBL_LO);
  wire f_ret     = op_is(INSTR_I, `NCT_OP_RETURN);
  wire f_callpfx = op_is(INSTR_I, `NCT_OP_CALL_PFX);
  wire f_allones = op_is(INSTR_I, `NCT_OP_ALL_ONES);
  wire f_jmp     = op_is(INSTR_I, `NCT_OP_JUMP_P0) | op_is(INSTR_I, `NCT_OP_JUMP_P1);
  wire f_branch  = op_is(INSTR_I, `NCT_OP_BCS_P0) | op_is(INSTR_I, `NCT_OP_BCS_P1)
                 | op_is(INSTR_I, `NCT_OP_BCC_P0) | op_is(INSTR_I, `NCT_OP_BCC_P1)
                 | op_is(INSTR_I, `NCT_OP_BFS_P0) | op_is(INSTR_I, `NCT_OP_BFS_P1)
                 | op_is(INSTR_I, `NCT_OP_BFC_P0) | op_is(INSTR_I, `NCT_OP_BFC_P1);
  // Any opcode that carries a second word
  wire f_two     = f_pimm | f_jmp | f_branch
                 | op_is(INSTR_I, `NCT_OP_MOVE_IMM) | op_is(INSTR_I, `NCT_OP_AND_IMM)
                 | op_is(INSTR_I, `NCT_OP_STATUS_IMM) | op_is(INSTR_I, `NCT_OP_STANDBY);

  // Second-word decode on the latched opcode
  wire o_page1 = op_is(op, `NCT_OP_JUMP_P1) | op_is(op, `NCT_OP_BCS_P1)
               | op_is(op, `NCT_OP_BCC_P1) | op_is(op, `NCT_OP_BFS_P1)
               | op_is(op, `NCT_OP_BFC_P1);
  wire o_jmp   = op_is(op, `NCT_OP_JUMP_P0) | op_is(op, `NCT_OP_JUMP_P1);
  wire o_taken = o_jmp
               | ((op_is(op, `NCT_OP_BCS_P0) | op_is(op, `NCT_OP_BCS_P1)) & cy)
               | ((op_is(op, `NCT_OP_BCC_P0) | op_is(op, `NCT_OP_BCC_P1)) & ~cy)
               | ((op_is(op, `NCT_OP_BFS_P0) | op_is(op, `NCT_OP_BFS_P1)) & flag)
               | ((op_is(op, `NCT_OP_BFC_P0) | op_is(op, `NCT_OP_BFC_P1)) & ~flag);
  wire [`NCT_W_PC-1:0] target = {o_page1, opnd8};
  wire [`NCT_W_PC-1:0] pc_inc = pc + `NCT_W_PC'(1);
  wire [3:0]           op_idx = op[3:0];

  always_comb begin
    next_state = NCT_FETCH;
    next_op    = op;
    next_call  = 1'b0;
    next_pc    = pc_inc;
    next_asr   = address_stack_reg;
    next_sp    = sp;
    next_acc   = acc;
    next_cy    = cy;
    next_flag  = flag;
    wr_b0      = 1'b0;
    wr_b1      = 1'b0;
    wr_d0      = acc;
    wr_d1      = acc;
    case (state)
      NCT_FETCH: begin
        next_op   = INSTR_I;
        next_call = f_callpfx | (call_q & f_jmp);
        if (f_two) begin
          next_state = NCT_OPERAND;
        end
        if (f_mov_b0 | f_mov_b1) begin
          next_acc = f_mov_b0 ? reg_b0 : reg_b1;
          next_cy  = 1'b0;
        end
        if (f_tbl_hi | f_tbl_lo) begin
          next_acc = f_tbl_hi ? tbl_hi : tbl_lo;
          next_cy  = 1'b0;
        end
        // Store leaves carry as it was
        wr_b0 = f_st_b0;
        wr_b1 = f_st_b1;
        // Pair zero is the pointer itself, so its table load is not decoded
        if (f_ptbl && idx != `NCT_IDX_ZERO) begin
          wr_b0 = 1'b1;
          wr_b1 = 1'b1;
          wr_d0 = tbl_lo;
          wr_d1 = tbl_hi;
        end
        if (f_and_b0 | f_and_b1) begin
          next_acc = acc & (f_and_b0 ? reg_b0 : reg_b1);
          next_cy  = acc[3] & (f_and_b0 ? reg_b0[3] : reg_b1[3]);
        end
        if (f_atbl_hi | f_atbl_lo) begin
          next_acc = acc & (f_atbl_hi ? tbl_hi : tbl_lo);
          next_cy  = acc[3] & (f_atbl_hi ? TBL_DATA_I[7] : TBL_DATA_I[3]);
        end
        if (f_sts_reg) begin
          next_flag = (STATUS_I == reg_b0);
        end
        if (f_allones) begin
          next_cy = (acc == `NCT_NIB_ONES);
        end
        if (f_ret) begin
          next_pc = address_stack_reg;
          next_sp = sp - `NCT_W_SP'(1);
        end
      end
      NCT_OPERAND: begin
        if (op_is(op, `NCT_OP_MOVE_IMM)) begin
          next_acc = opnd4;
          next_cy  = 1'b0;
        end
        if (op_is(op, `NCT_OP_AND_IMM)) begin
          next_acc = acc & opnd4;
          next_cy  = acc[3] & opnd4[3];
        end
        if (op_is(op, `NCT_OP_STATUS_IMM)) begin
          next_flag = (STATUS_I == opnd4);
        end
        if (grp_is(op, `NCT_G_PAIR_IMM)) begin
          wr_b0 = 1'b1;
          wr_b1 = 1'b1;
          wr_d0 = opnd8[3:0];
          wr_d1 = opnd8[7:4];
        end
        // Not taken falls through: PC of first word plus two
        if (o_taken) begin
          next_pc = target;
        end
        if (call_q && o_jmp) begin
          next_sp  = sp + `NCT_W_SP'(1);
          next_asr = pc_inc;
        end
      end
      default: begin
        next_state = NCT_FETCH;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state  <= NCT_FETCH;
      op     <= '0;
      call_q <= 1'b0;
      pc     <= `NCT_PC_RST;
      address_stack_reg    <= `NCT_PC_RST;
      sp     <= `NCT_SP_RST;
      acc    <= `NCT_NIB_RST;
      cy     <= 1'b0;
      flag   <= 1'b0;
    end else begin
      state  <= next_state;
      op     <= next_op;
      call_q <= next_call;
      pc     <= next_pc;
      address_stack_reg    <= next_asr;
      sp     <= next_sp;
      acc    <= next_acc;
      cy     <= next_cy;
      flag   <= next_flag;
    end
  end

  // Register write index comes from the word being executed
  wire [3:0] wr_idx = (state == NCT_OPERAND) ? op_idx : idx;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < `NCT_NREG; i++) begin
        bank0[i] <= `NCT_NIB_RST;
        bank1[i] <= `NCT_NIB_RST;
      end
    end else begin
      if (wr_b0) begin
        bank0[wr_idx] <= wr_d0;
      end
      if (wr_b1) begin
        bank1[wr_idx] <= wr_d1;
      end
    end
  end

  assign PC_O   = pc;
  // One driver for the whole struct keeps the output a single writer
  assign CORE_O = '{pc: pc, sp: sp, address_stack_reg: address_stack_reg, acc: acc, carry: cy, flag: flag};
endmodule
`default_nettype wire

//--- hdl/nct_params.svh
// Constants of the nibble core: widths, opcodes, reset values.
// Notes on behaviour
// - Register to accumulator copies, clears carry
// - Table high/low nibble into accumulator, clears carry
// - Table address is pointer over pair zero
// - Accumulator to register, carry untouched
// - Pair immediate load, indices zero to F
// - Pair load from table, indices one to F
// - Jumps take target word; false branch skips two
// - Carry/flag branches, own opcode per page
// - Call: three words, push PC, load target
// - Return: restore PC, decrement stack pointer
// - Status test sets flag on match
// - AND register; carry from both bit threes
// - AND table nibble; carry from bit 7/3
// - AND immediate; carry from both bit threes
// - Same-index bank registers form one pair
`ifndef NCT_PARAMS_SVH
`define NCT_PARAMS_SVH
`define NCT_W_INSTR 16
`define NCT_W_PC 9
`define NCT_W_ROMPTR 1
`define NCT_W_TBL 10
`define NCT_W_SP 2
`define NCT_NREG 16
`define NCT_PC_RST 9'h000
`define NCT_SP_RST 2'h0
`define NCT_NIB_RST 4'h0
`define NCT_NIB_ONES 4'hF
`define NCT_IDX_ZERO 4'h0
// Twelve-bit groups whose low nibble is a register index
`define NCT_G_MOVE_ACC_B0 12'hFFE
`define NCT_G_MOVE_ACC_B1 12'hFEE
`define NCT_G_MOVE_B0_ACC 12'hE5E
`define NCT_G_MOVE_B1_ACC 12'hE4E
`define NCT_G_PAIR_IMM 12'hE6E
`define NCT_G_PAIR_TBL 12'hE7E
`define NCT_G_AND_B0 12'hFBE
`define NCT_G_AND_B1 12'hFAE
`define NCT_G_STATUS_REG 12'hE3E
// Whole-word opcodes
`define NCT_OP_MOVE_TBL_HI 16'hFEF0
`define NCT_OP_MOVE_TBL_LO 16'hFFF0
`define NCT_OP_MOVE_IMM 16'hFFF1
`define NCT_OP_AND_TBL_HI 16'hFAF0
`define NCT_OP_AND_TBL_LO 16'hFBF0
`define NCT_OP_AND_IMM 16'hFBF1
`define NCT_OP_JUMP_P0 16'hE8F1
`define NCT_OP_JUMP_P1 16'hE9F1
`define NCT_OP_BCS_P0 16'hECF1
`define NCT_OP_BCS_P1 16'hEAF1
`define NCT_OP_BCC_P0 16'hEDF1
`define NCT_OP_BCC_P1 16'hEBF1
`define NCT_OP_BFS_P0 16'hEEF1
`define NCT_OP_BFS_P1 16'hF0F1
`define NCT_OP_BFC_P0 16'hEFF1
`define NCT_OP_BFC_P1 16'hF1F1
`define NCT_OP_CALL_PFX 16'hE6F2
`define NCT_OP_RETURN 16'hE8F2
`define NCT_OP_STATUS_IMM 16'hE3F1
`define NCT_OP_STANDBY 16'hE2F1
`define NCT_OP_ALL_ONES 16'hFAF3
`endif

//--- hdl/nct_pkg.sv
// Types shared by the nibble core and its bench.
`default_nettype none
`include "nct_params.svh"
package nct_pkg;
  typedef enum logic {NCT_FETCH, NCT_OPERAND} nct_state_e;
  typedef struct packed {
    logic [`NCT_W_PC-1:0] pc;
    logic [`NCT_W_SP-1:0] sp;
    logic [`NCT_W_PC-1:0] address_stack_reg;
    logic [3:0]           acc;
    logic                 carry;
    logic                 flag;
  } nct_core_s;
endpackage
`default_nettype wire

//--- tb/nct_core_bench.sv
// Self-checking bench of the nibble core.
`default_nettype none
`include "nct_params.svh"
module nct_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import nct_pkg::*;
  logic        clk = 0;
  logic        rst_n = 0;
  logic [8:0]  pc, ta, m_pc, ret;
  logic [15:0] ins;
  logic [9:0]  td, t;
  logic        ptr = 0, cy, f;
  logic [3:0]  sts = 0, d, a;
  logic [4:0]  c5;
  logic [7:0]  p, q;
  nct_core_s   core;
  int          err_total = 0, check_count = 0, cyc = 0, seed = 32'h8f7aba4c;
  logic [15:0] ops [10] = '{16'hE8F1, 16'hE9F1, 16'hECF1, 16'hEAF1, 16'hEDF1,
                            16'hEBF1, 16'hEEF1, 16'hF0F1, 16'hEFF1, 16'hF1F1};
  initial forever #5 clk = ~clk;
  nct_core dut (.MCLK_I(clk), .RST_N_I(rst_n), .PC_O(pc), .INSTR_I(ins), .TBL_ADDR_O(ta),
    .TBL_DATA_I(td), .ROM_PTR_I(ptr), .STATUS_I(sts), .CORE_O(core));
  nct_rom rom (.pc_i(pc), .instr_o(ins), .tbl_addr_i(ta), .tbl_data_o(td));
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (e !== g) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task end_sim;
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Words go in at the model's PC, one word per clock
  task run(input logic [15:0] w0, w1 = 0, w2 = 0, input int n = 1);
    rom.code[m_pc] = w0;
    rom.code[m_pc + 9'd1] = w1;
    rom.code[m_pc + 9'd2] = w2;
    repeat (n) @(posedge clk);
    #1;
    m_pc = m_pc + 9'(n);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      err_total++;
      end_sim;
    end
  end
  initial begin
    for (int i = 0; i < 512; i++) begin
      rom.tbl[i] = 10'($random(seed));
      rom.code[i] = 0;
    end
    m_pc = 0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    chk("reset", 0, core[15:0]);
    for (int k = 0; k < 8; k++) begin
      d = 4'($random(seed));
      p = 8'($random(seed));
      ptr = 1'($random(seed));
      sts = 4'($random(seed));
      run(16'hFFF1, {12'h0, d}, , 2);
      run(16'hFBF1, 16'h000F, , 2);
      run(16'hE5E0);
      chk("carry", d[3], core.carry);
      run(16'hFFE0);
      chk("acc", {d, 1'b0}, {core.acc, core.carry});
      run(16'hE6E0, {8'h0, p}, , 2);
      chk("taddr", {ptr, p}, ta);
      t = rom.tbl[{ptr, p}];
      run(16'hFEF0);
      chk("acc", {t[7:4], 1'b0}, {core.acc, core.carry});
      run(16'hFFF0);
      chk("acc", {t[3:0], 1'b0}, {core.acc, core.carry});
      run(16'hFAF0);
      a = t[3:0] & t[7:4];
      chk("acc", {a, t[3] & t[7]}, {core.acc, core.carry});
      run(16'hFBE0);
      chk("acc", {a & p[3:0], a[3] & p[3]}, {core.acc, core.carry});
      run(16'hE7E5);
      run(16'hFEE5);
      chk("acc", t[7:4], core.acc);
      run(16'hFFE5);
      chk("acc", t[3:0], core.acc);
      run(16'hE3E0);
      chk("flag", sts == p[3:0], core.flag);
      // Pair other than zero, bank 1 store, AND with bank 1
      q = ~p;
      run(16'hE6E9, {8'h0, q}, , 2);
      run(16'hFEE9);
      chk("acc", q[7:4], core.acc);
      run(16'hFFE9);
      chk("acc", q[3:0], core.acc);
      run(16'hE4E9);
      run(16'hFFF1, {12'h0, d}, , 2);
      run(16'hFAE9);
      chk("acc", {d & q[3:0], d[3] & q[3]}, {core.acc, core.carry});
      // Pair zero holds the pointer, its table load must not land
      run(16'hE7E0);
      chk("taddr", {ptr, p}, ta);
      // Standby only skips its operand
      run(16'hE2F1, {12'h0, d}, , 2);
      chk("pc", m_pc, pc);
      // All-ones test, forced true on odd passes
      a = d | {4{k[0]}};
      run(16'hFFF1, {12'h0, a}, , 2);
      run(16'hFAF3);
      chk("carry", a == 4'hF, core.carry);
      cy = k[0];
      f = k[1];
      c5 = {!f, f, !cy, cy, 1'b1};
      run(16'hFFF1, 16'h0008, , 2);
      run(16'hFBF1, {12'h0, cy, 3'h0}, , 2);
      run(16'hE3F1, {12'h0, f ? sts : ~sts}, , 2);
      chk("flag", f, core.flag);
      for (int j = 0; j < 10; j++) begin
        run(ops[j], {8'h0, p}, , 2);
        if (c5[j / 2]) m_pc = {j[0], p};
        chk("pc", m_pc, pc);
      end
      ret = m_pc + 9'd3;
      run(16'hE6F2, k[2] ? 16'hE9F1 : 16'hE8F1, {8'h0, p}, 3);
      chk("pc", {k[2], p}, pc);
      chk("asr", ret, core.address_stack_reg);
      chk("sp", 1, core.sp);
      m_pc = {k[2], p};
      run(16'hE8F2);
      chk("pc", ret, pc);
      chk("sp", 0, core.sp);
      m_pc = ret;
    end
    end_sim;
  end
endmodule
`default_nettype wire

//--- tb/nct_core_monitor.sv
// Port checker of the nibble core.
`default_nettype none
`include "nct_params.svh"
module nct_core_monitor import nct_pkg::*; (
  input wire logic                     MCLK_I,
  input wire logic                     RST_N_I,
  input wire logic [`NCT_W_PC-1:0]     PC_O,
  input wire logic [`NCT_W_INSTR-1:0]  INSTR_I,
  input wire logic [`NCT_W_PC-1:0]     TBL_ADDR_O,
  input wire logic [`NCT_W_TBL-1:0]    TBL_DATA_I,
  input wire logic [`NCT_W_ROMPTR-1:0] ROM_PTR_I,
  input wire logic [3:0]               STATUS_I,
  input wire nct_core_s                CORE_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  table_page_a: assert property (TBL_ADDR_O[8] == ROM_PTR_I)
    else $error("table page bit wrong");
  reg_move_a: assert property (INSTR_I == 16'hFFE0 |=>
    CORE_O.acc == $past(TBL_ADDR_O[3:0]) && !CORE_O.carry) else $error("register move wrong");
  tbl_move_a: assert property (INSTR_I == 16'hFEF0 |=>
    CORE_O.acc == $past(TBL_DATA_I[7:4]) && !CORE_O.carry) else $error("table move wrong");
  acc_store_a: assert property (INSTR_I == 16'hE5E0 |=>
    TBL_ADDR_O[3:0] == $past(CORE_O.acc) && $stable(CORE_O.carry)) else $error("store wrong");
  pair_load_a: assert property (INSTR_I == 16'hE6E0 ##1 1 |=>
    TBL_ADDR_O[7:0] == $past(INSTR_I[7:0])) else $error("pair load wrong");
  branch_skip_a: assert property (INSTR_I == 16'hECF1 && !CORE_O.carry ##1 1 |=>
    PC_O == $past(PC_O, 2) + 9'h002) else $error("branch skip wrong");
  call_seq_a: assert property (INSTR_I == 16'hE6F2 ##1 INSTR_I == 16'hE8F1 ##1 1 |=>
    PC_O == {1'b0, $past(INSTR_I[7:0])} && CORE_O.address_stack_reg == $past(PC_O) + 9'h001
    && CORE_O.sp == $past(CORE_O.sp) + 2'h1) else $error("call wrong");
  return_a: assert property (INSTR_I == 16'hE8F2 |=> PC_O == $past(CORE_O.address_stack_reg)
    && CORE_O.sp == $past(CORE_O.sp) - 2'h1) else $error("return wrong");
  status_imm_a: assert property (INSTR_I == 16'hE3F1 ##1 1 |=>
    CORE_O.flag == ($past(STATUS_I) == $past(INSTR_I[3:0]))) else $error("status wrong");
  and_tbl_a: assert property (INSTR_I == 16'hFAF0 |=>
    CORE_O.acc == $past(CORE_O.acc & TBL_DATA_I[7:4])
    && CORE_O.carry == $past(CORE_O.acc[3] & TBL_DATA_I[7])) else $error("table and wrong");
endmodule
bind nct_core nct_core_monitor mon (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .PC_O(PC_O),
  .INSTR_I(INSTR_I), .TBL_ADDR_O(TBL_ADDR_O), .TBL_DATA_I(TBL_DATA_I),
  .ROM_PTR_I(ROM_PTR_I), .STATUS_I(STATUS_I), .CORE_O(CORE_O));
`default_nettype wire

//--- tb/nct_rom.sv
// Program memory model: instruction and table words, read without delay.
`default_nettype none
`include "nct_params.svh"
module nct_rom (
  input  wire logic [`NCT_W_PC-1:0]    pc_i,
  output logic      [`NCT_W_INSTR-1:0] instr_o,
  input  wire logic [`NCT_W_PC-1:0]    tbl_addr_i,
  output logic      [`NCT_W_TBL-1:0]   tbl_data_o
);
  logic [`NCT_W_INSTR-1:0] code [512];
  logic [`NCT_W_TBL-1:0]   tbl  [512];
  assign instr_o = code[pc_i];
  // Same-cycle read, the core samples both words at one edge
  assign tbl_data_o = tbl[tbl_addr_i];
endmodule
`default_nettype wire
